/* File: cisc_ctrl.sv */
// stack pointer, interrupt entry and return, and change protection
//
// Behaviour
// - push stores then decrements pointer by one; pop increments first then reads
// - calls and interrupt entry push two-byte return address, pointer minus two
// - returns pop two-byte address into program counter, pointer plus two
// - stack pointer resets to last internal sram address
// - pointer held in low and high byte registers; high byte optional
// - single undivided clock; fetch overlaps execute, one-cycle alu op
// - source taken only when own enable and global enable are set
// - lower vector wins; external request zero first after reset
// - entry clears global enable; software may set it; return sets it
// - vectoring clears the flag; writing one also clears it
// - flags raised while disabled stay until enabled or cleared
// - level sources request only while their condition is present
// - one main instruction runs after return before next interrupt
// - entry and return leave the status flags untouched
// - clear-enable blocks interrupts at once, same cycle included
// - instruction after set-enable runs before any interrupt
// - entry takes four cycles pushing counter before vector runs
// - multi-cycle instructions finish first; sleep adds four cycles
// - return takes four cycles, pops counter, sets global enable
// - key 0xD8 opens protected writes for the next four cycles
// - interrupts ignored while the protected window is open
// - key bit 0 reads window open; bits 7 to 1 read zero
// - global enable is bit 7 of flags register at 0x3F, reset zero
// - pointer high byte at 0x3E, low byte at 0x3D
`timescale 1ns/1ps
module cisc_ctrl #(
  parameter int          N_SRC      = 8,
  parameter logic [7:0]  LEVEL_MASK = 8'h00,
  parameter logic [15:0] SP_RESET   = cisc_pkg::CISC_SRAM_LAST,
  parameter bit          SP_HIGH_EN = 1'b1
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // register port
  input  wire logic [5:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  // instruction stream
  input  wire logic                     instr_done,
  input  wire logic                     op_push,
  input  wire logic                     op_pop,
  input  wire logic                     op_call,
  input  wire logic                     op_ret,
  input  wire logic                     op_interrupt_return,
  input  wire logic                     op_sei,
  input  wire logic                     op_cli,
  input  wire logic                     asleep,
  input  wire logic [7:0]               push_data,
  input  wire logic [15:0]              ret_pc,
  // peripheral interrupt sources
  input  wire logic [N_SRC-1:0]         irq_evt,
  input  wire logic [N_SRC-1:0]         irq_lvl,
  // stack memory
  output logic                          mem_we,
  output logic                          mem_re,
  output logic      [15:0]              mem_addr,
  output logic      [7:0]               mem_wdata,
  input  wire logic [7:0]               mem_rdata,
  // core control
  output logic                          core_stall,
  output logic                          vec_valid,
  output logic      [$clog2(N_SRC)-1:0] vec_num,
  output logic                          pc_load,
  output logic      [15:0]              pc_value,
  // protected registers and key window state
  output logic      [7:0]               clock_source_select,
  output logic      [7:0]               clock_prescale_select,
  output logic      [7:0]               watchdog_ctrl_status,
  output logic                          key_open
);

  localparam int IW = $clog2(N_SRC);

  initial begin
    if (N_SRC < 2 || N_SRC > 8) $error("N_SRC must be 2 to 8");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  cisc_pkg::cisc_state_t state_q, state_d;
  logic [1:0]     cnt_q, cnt_d;
  logic           irq_seq_q, irq_seq_d;
  logic           interrupt_return_q, interrupt_return_d;
  logic [15:0]    sp_q, sp_d;
  logic [7:0]     flags_q, flags_d;
  logic [7:0]     irq_en_q;
  logic [2:0]     win_q, win_d;
  logic           hold_q, hold_d;
  logic [15:0]    ret_q;
  logic [7:0]     pc_hi_q;
  logic [IW-1:0]  idx_q;
  logic [7:0]     clk_src_q, clk_psc_q, wdog_q;
  logic [7:0]     rdata_q;
  logic           mem_we_q, mem_we_d, mem_re_q, mem_re_d;
  logic [15:0]    mem_addr_q, mem_addr_d;
  logic [7:0]     mem_wdata_q, mem_wdata_d;
  logic           vec_q, pc_load_q;
  logic [15:0]    pc_q;
  logic [N_SRC-1:0] arb_flags;
  logic           pend_any;
  logic [IW-1:0]  win_idx;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire wr_flags = reg_wr && reg_addr == cisc_pkg::CISC_OFS_FLAGS;
  wire wr_sph   = reg_wr && reg_addr == cisc_pkg::CISC_OFS_SP_HIGH;
  wire wr_spl   = reg_wr && reg_addr == cisc_pkg::CISC_OFS_SP_LOW;
  wire wr_key   = reg_wr && reg_addr == cisc_pkg::CISC_OFS_KEY;
  wire wr_en    = reg_wr && reg_addr == cisc_pkg::CISC_OFS_IRQ_EN;
  wire wr_flag  = reg_wr && reg_addr == cisc_pkg::CISC_OFS_IRQ_FLAG;
  wire wr_src   = reg_wr && reg_addr == cisc_pkg::CISC_OFS_CLK_SRC;
  wire wr_psc   = reg_wr && reg_addr == cisc_pkg::CISC_OFS_CLK_PSC;
  wire wr_wdog  = reg_wr && reg_addr == cisc_pkg::CISC_OFS_WDOG;
  wire win_open = win_q != 3'h0;
  wire gie      = flags_q[cisc_pkg::CISC_GIE_BIT];
  wire seq_end  = cnt_q == cisc_pkg::CISC_SEQ_LAST;
  wire [N_SRC-1:0] clr_mask = wr_flag ? reg_wdata[N_SRC-1:0] : '0;

  // boundary is instruction retire, one cycle per simple op
  // multi-cycle ops retire only when finished
  wire boundary = instr_done || asleep;
  // cli in the same cycle blocks the take
  wire take = state_q == cisc_pkg::CISC_RUN && boundary && gie &&
              !op_cli && !hold_q && !win_open && pend_any;

  // ------------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------------
  cisc_irq_arb #(
    .N_SRC      (N_SRC),
    .LEVEL_MASK (LEVEL_MASK)
  ) u_arb (
    .clk      (clk),
    .resetn   (resetn),
    .irq_evt  (irq_evt),
    .irq_lvl  (irq_lvl),
    .irq_en   (irq_en_q[N_SRC-1:0]),
    .ack      (take),
    .ack_idx  (win_idx),
    .clr_mask (clr_mask),
    .flags_q  (arb_flags),
    .pend_any (pend_any),
    .win_idx  (win_idx)
  );

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    irq_seq_d   = irq_seq_q;
    interrupt_return_d      = interrupt_return_q;
    sp_d        = sp_q;
    mem_we_d    = 1'b0;
    mem_re_d    = 1'b0;
    mem_addr_d  = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    unique case (state_q)
      cisc_pkg::CISC_RUN: begin
        cnt_d = 2'h0;
        if (take) begin
          irq_seq_d = 1'b1;
          state_d   = asleep ? cisc_pkg::CISC_WAKE : cisc_pkg::CISC_PUSH;
        end else if (op_call) begin
          irq_seq_d = 1'b0;
          state_d   = cisc_pkg::CISC_PUSH;
        end else if (op_ret || op_interrupt_return) begin
          interrupt_return_d  = op_interrupt_return;
          state_d = cisc_pkg::CISC_POP;
        end else if (op_push) begin
          mem_we_d    = 1'b1;
          mem_addr_d  = sp_q;
          mem_wdata_d = push_data;
          sp_d        = sp_q - 16'h0001;
        end else if (op_pop) begin
          mem_re_d   = 1'b1;
          mem_addr_d = sp_q + 16'h0001;
          sp_d       = sp_q + 16'h0001;
        end
      end
      cisc_pkg::CISC_WAKE: begin
        cnt_d = cnt_q + 2'h1;
        if (seq_end) begin
          cnt_d   = 2'h0;
          state_d = cisc_pkg::CISC_PUSH;
        end
      end
      cisc_pkg::CISC_PUSH: begin
        cnt_d = cnt_q + 2'h1;
        // low byte at sp, high byte at sp-1
        if (cnt_q == 2'h0) begin
          mem_we_d    = 1'b1;
          mem_addr_d  = sp_q;
          mem_wdata_d = ret_q[7:0];
        end else if (cnt_q == 2'h1) begin
          mem_we_d    = 1'b1;
          mem_addr_d  = sp_q - 16'h0001;
          mem_wdata_d = ret_q[15:8];
          sp_d        = sp_q - 16'h0002;
          if (!irq_seq_q) state_d = cisc_pkg::CISC_RUN;
        end
        if (seq_end) state_d = cisc_pkg::CISC_RUN;
      end
      cisc_pkg::CISC_POP: begin
        cnt_d = cnt_q + 2'h1;
        // read high then low, pointer plus two
        if (cnt_q == 2'h0) begin
          mem_re_d   = 1'b1;
          mem_addr_d = sp_q + 16'h0001;
        end else if (cnt_q == 2'h1) begin
          mem_re_d   = 1'b1;
          mem_addr_d = sp_q + 16'h0002;
          sp_d       = sp_q + 16'h0002;
        end
        if (seq_end) state_d = cisc_pkg::CISC_RUN;
      end
      default: state_d = cisc_pkg::CISC_RUN;
    endcase
    if (wr_sph && SP_HIGH_EN) sp_d[15:8] = reg_wdata;
    if (wr_spl)               sp_d[7:0]  = reg_wdata;
    if (!SP_HIGH_EN)          sp_d[15:8] = 8'h00;
  end

  // ------------------------------------------------------------------
  // global enable, hold and key window
  // ------------------------------------------------------------------
  wire interrupt_return_end = state_q == cisc_pkg::CISC_POP && seq_end && interrupt_return_q;

  always_comb begin
    // only bit 7 is touched by hardware
    flags_d = wr_flags ? reg_wdata : flags_q;
    // entry clears, return and sei set
    if (take)                     flags_d[cisc_pkg::CISC_GIE_BIT] = 1'b0;
    else if (op_cli)              flags_d[cisc_pkg::CISC_GIE_BIT] = 1'b0;
    else if (op_sei || interrupt_return_end)  flags_d[cisc_pkg::CISC_GIE_BIT] = 1'b1;
    hold_d = hold_q;
    if (op_sei || interrupt_return_end)  hold_d = 1'b1;
    else if (instr_done)     hold_d = 1'b0;
    win_d = win_open ? win_q - 3'h1 : 3'h0;
    if (wr_key && reg_wdata == cisc_pkg::CISC_KEY_VALUE)
      win_d = cisc_pkg::CISC_KEY_LOAD;
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      cisc_pkg::CISC_OFS_FLAGS:    rd_mux = flags_q;
      cisc_pkg::CISC_OFS_SP_HIGH:  rd_mux = sp_q[15:8];
      cisc_pkg::CISC_OFS_SP_LOW:   rd_mux = sp_q[7:0];
      // only the open bit reads back
      cisc_pkg::CISC_OFS_KEY:      rd_mux = {7'h00, win_open};
      cisc_pkg::CISC_OFS_IRQ_EN:   rd_mux = irq_en_q;
      cisc_pkg::CISC_OFS_IRQ_FLAG: rd_mux = 8'(arb_flags);
      cisc_pkg::CISC_OFS_CLK_SRC:  rd_mux = clk_src_q;
      cisc_pkg::CISC_OFS_CLK_PSC:  rd_mux = clk_psc_q;
      cisc_pkg::CISC_OFS_WDOG:     rd_mux = wdog_q;
      default:                     rd_mux = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= cisc_pkg::CISC_RUN;
      cnt_q     <= 2'h0;
      irq_seq_q <= 1'b0;
      interrupt_return_q    <= 1'b0;
      // pointer starts at last sram byte
      sp_q      <= SP_HIGH_EN ? SP_RESET : {8'h00, SP_RESET[7:0]};
      flags_q   <= cisc_pkg::CISC_FLAGS_RST;
      hold_q    <= 1'b0;
      win_q     <= 3'h0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      irq_seq_q <= irq_seq_d;
      interrupt_return_q    <= interrupt_return_d;
      sp_q      <= sp_d;
      flags_q   <= flags_d;
      hold_q    <= hold_d;
      win_q     <= win_d;
    end
  end

  // protected writes only land inside the window
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_q  <= cisc_pkg::CISC_IRQ_EN_RST;
      clk_src_q <= cisc_pkg::CISC_PROT_RST;
      clk_psc_q <= cisc_pkg::CISC_PROT_RST;
      wdog_q    <= cisc_pkg::CISC_PROT_RST;
      rdata_q   <= 8'h00;
    end else begin
      if (wr_en) irq_en_q <= reg_wdata;
      if (wr_src && win_open)  clk_src_q <= reg_wdata;
      if (wr_psc && win_open)  clk_psc_q <= reg_wdata;
      if (wr_wdog && win_open) wdog_q    <= reg_wdata;
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // return address, popped bytes and core strobes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ret_q       <= 16'h0000;
      pc_hi_q     <= 8'h00;
      idx_q       <= '0;
      mem_we_q    <= 1'b0;
      mem_re_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= 8'h00;
      vec_q       <= 1'b0;
      pc_load_q   <= 1'b0;
      pc_q        <= 16'h0000;
    end else begin
      if (state_q == cisc_pkg::CISC_RUN) ret_q <= ret_pc;
      if (take) idx_q <= win_idx;
      mem_we_q    <= mem_we_d;
      mem_re_q    <= mem_re_d;
      mem_addr_q  <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      vec_q <= state_q == cisc_pkg::CISC_PUSH && seq_end && irq_seq_q;
      if (state_q == cisc_pkg::CISC_POP && cnt_q == 2'h2)
        pc_hi_q <= mem_rdata;
      pc_load_q <= state_q == cisc_pkg::CISC_POP && seq_end;
      if (state_q == cisc_pkg::CISC_POP && seq_end)
        pc_q <= {pc_hi_q, mem_rdata};
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  logic stall_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) stall_q <= 1'b0;
    else         stall_q <= state_d != cisc_pkg::CISC_RUN;
  end

  assign reg_rdata             = rdata_q;
  assign mem_we                = mem_we_q;
  assign mem_re                = mem_re_q;
  assign mem_addr              = mem_addr_q;
  assign mem_wdata             = mem_wdata_q;
  assign core_stall            = stall_q;
  assign vec_valid             = vec_q;
  assign vec_num               = idx_q;
  assign pc_load               = pc_load_q;
  assign pc_value              = pc_q;
  assign clock_source_select   = clk_src_q;
  assign clock_prescale_select = clk_psc_q;
  assign watchdog_ctrl_status  = wdog_q;
  assign key_open              = win_q != 3'h0;

endmodule : cisc_ctrl

/* File: cisc_ctrl_checker.sv */
// port assertions for the interrupt and stack control
`timescale 1ns/1ps
module cisc_ctrl_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // register port
  input wire logic [5:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // instruction stream
  input wire logic        op_push,
  input wire logic        op_call,
  input wire logic        op_ret,
  input wire logic        op_interrupt_return,
  input wire logic        op_cli,
  input wire logic [7:0]  push_data,
  input wire logic [15:0] ret_pc,
  // stack and core side
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic        core_stall,
  input wire logic        vec_valid,
  input wire logic        pc_load,
  input wire logic [7:0]  clock_source_select,
  input wire logic        key_open
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  key_win_a: assert property (
    reg_wr && reg_addr == 6'h3C && reg_wdata == 8'hD8 && !key_open
    |=> key_open [*4] ##1 !key_open) else $error("key window length");
  key_read_a: assert property (
    reg_rd && reg_addr == 6'h3C |=> reg_rdata == {7'h00, $past(key_open)})
    else $error("key readback wrong");
  prot_block_a: assert property (
    reg_wr && reg_addr == 6'h39 && !key_open
    |=> $stable(clock_source_select)) else $error("locked write taken");
  prot_take_a: assert property (
    reg_wr && reg_addr == 6'h39 && key_open
    |=> clock_source_select == $past(reg_wdata)) else $error("open write lost");
  push_store_a: assert property (
    op_push && !core_stall |=> mem_we && mem_wdata == $past(push_data))
    else $error("push not stored");
  call_push_a: assert property (
    op_call |=> ##1 mem_we && mem_wdata == $past(ret_pc[7:0], 2) ##1 mem_we
    && mem_addr == $past(mem_addr) - 16'h0001
    && mem_wdata == $past(ret_pc[15:8], 3)) else $error("call push wrong");
  ret_pop_a: assert property (
    op_ret || op_interrupt_return |=> core_stall && !mem_re ##1 mem_re && core_stall
    ##1 mem_re && mem_addr == $past(mem_addr) + 16'h0001 ##1 core_stall
    ##1 pc_load && !core_stall) else $error("return sequence wrong");
  entry_time_a: assert property (
    vec_valid |-> $past(core_stall) && $past(core_stall, 4) && !core_stall)
    else $error("entry not four cycles");
  vec_gap_a: assert property (
    vec_valid |=> !vec_valid [*5]) else $error("vector repeated");
  cli_block_a: assert property (
    op_cli && !core_stall |=> !core_stall) else $error("taken with cli");
  key_mute_a: assert property (
    key_open && !core_stall && !op_call && !op_ret && !op_interrupt_return
    |=> !core_stall) else $error("taken in window");
endmodule : cisc_ctrl_checker

bind cisc_ctrl cisc_ctrl_checker u_chk (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .op_push(op_push), .op_call(op_call), .op_ret(op_ret),
  .op_interrupt_return(op_interrupt_return), .op_cli(op_cli), .push_data(push_data),
  .ret_pc(ret_pc), .mem_we(mem_we), .mem_re(mem_re), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .core_stall(core_stall), .vec_valid(vec_valid),
  .pc_load(pc_load), .clock_source_select(clock_source_select),
  .key_open(key_open));

/* File: cisc_irq_arb.sv */
// interrupt flags, enables and fixed priority arbitration
`timescale 1ns/1ps
module cisc_irq_arb #(
  parameter int             N_SRC      = 8,
  parameter logic [7:0]     LEVEL_MASK = 8'h00
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // sources
  input  wire logic [N_SRC-1:0]         irq_evt,
  input  wire logic [N_SRC-1:0]         irq_lvl,
  input  wire logic [N_SRC-1:0]         irq_en,
  // clears
  input  wire logic                     ack,
  input  wire logic [$clog2(N_SRC)-1:0] ack_idx,
  input  wire logic [N_SRC-1:0]         clr_mask,
  // results
  output logic      [N_SRC-1:0]         flags_q,
  output logic                          pend_any,
  output logic      [$clog2(N_SRC)-1:0] win_idx
);

  localparam logic [N_SRC-1:0] LVL = LEVEL_MASK[N_SRC-1:0];

  initial begin
    if (N_SRC < 2 || N_SRC > 8) $error("N_SRC must be 2 to 8");
  end

  logic [N_SRC-1:0] flags_d;
  logic [N_SRC-1:0] ack_mask;
  logic [N_SRC-1:0] pend;

  // hardware and w1c clear
  // set wins over clear so a same-cycle event is kept
  assign ack_mask = ack ? (N_SRC'(1) << ack_idx) : '0;
  assign flags_d  = ((flags_q & ~ack_mask & ~clr_mask) | irq_evt) & ~LVL;
  assign pend     = ((flags_q & ~LVL) | (irq_lvl & LVL)) & irq_en;
  assign pend_any = |pend;

  always_comb begin
    win_idx = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (pend[i]) win_idx = ($clog2(N_SRC))'(i);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) flags_q <= '0;
    else         flags_q <= flags_d;
  end

endmodule : cisc_irq_arb

/* File: cisc_pkg.sv */
// constants, offsets and state codes of the interrupt and stack control
package cisc_pkg;

  // ------------------------------------------------------------------
  // register offsets in i/o space
  // ------------------------------------------------------------------
  localparam logic [5:0] CISC_OFS_FLAGS    = 6'h3F;
  localparam logic [5:0] CISC_OFS_SP_HIGH  = 6'h3E;
  localparam logic [5:0] CISC_OFS_SP_LOW   = 6'h3D;
  localparam logic [5:0] CISC_OFS_KEY      = 6'h3C;
  localparam logic [5:0] CISC_OFS_IRQ_EN   = 6'h3B;
  localparam logic [5:0] CISC_OFS_IRQ_FLAG = 6'h3A;
  localparam logic [5:0] CISC_OFS_CLK_SRC  = 6'h39;
  localparam logic [5:0] CISC_OFS_CLK_PSC  = 6'h38;
  localparam logic [5:0] CISC_OFS_WDOG     = 6'h37;

  // ------------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------------
  localparam int          CISC_GIE_BIT      = 7;
  localparam int          CISC_KEY_OPEN_BIT = 0;
  localparam logic [7:0]  CISC_KEY_VALUE    = 8'hD8;
  localparam logic [7:0]  CISC_FLAGS_RST    = 8'h00;
  localparam logic [7:0]  CISC_IRQ_EN_RST   = 8'h00;
  localparam logic [7:0]  CISC_PROT_RST     = 8'h00;
  localparam logic [15:0] CISC_SRAM_LAST    = 16'h005F;

  // ------------------------------------------------------------------
  // timing counts in clock cycles
  // ------------------------------------------------------------------
  localparam int         CISC_KEY_WIN   = 4;
  localparam int         CISC_SEQ_CYC   = 4;
  localparam logic [2:0] CISC_KEY_LOAD  = 3'(CISC_KEY_WIN);
  localparam logic [1:0] CISC_SEQ_LAST  = 2'(CISC_SEQ_CYC - 1);

  // ------------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    CISC_RUN  = 2'b00,
    CISC_PUSH = 2'b01,
    CISC_POP  = 2'b10,
    CISC_WAKE = 2'b11
  } cisc_state_t;

endpackage : cisc_pkg

/* File: cisc_stack_mem.sv */
// behavioural stack memory on the far side of the stack port
`timescale 1ns/1ps
module cisc_stack_mem (
  // clock
  input wire logic        clk,
  // stack port
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  output logic      [7:0] mem_rdata
);
  logic [7:0] ram [256];
  initial mem_rdata = 8'hA5;
  always @(posedge clk) begin
    if (mem_we) ram[mem_addr[7:0]] <= mem_wdata;
    // data valid one cycle only; inverted after so stale reads show
    mem_rdata <= mem_re ? ram[mem_addr[7:0]] : ~mem_rdata;
  end
endmodule : cisc_stack_mem

/* File: test_cisc_ctrl.sv */
// self-checking bench for the interrupt and stack control
`timescale 1ns/1ps
module test_cisc_ctrl;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam logic [5:0] PUSH = 6'h20, POP = 6'h10, CALL = 6'h08;
  localparam logic [5:0] RET = 6'h04, INTERRUPT_RETURN = 6'h02, CLEAR_GLOBAL_IRQ = 6'h01;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic instr_done = 1'b0, rd_d = 1'b0, sei = 1'b0;
  logic [5:0] reg_addr = 6'h00, ops = 6'h00;
  logic [7:0] reg_wdata = 8'h00, push_data = 8'h00, irq_evt = 8'h00;
  logic [15:0] ret_pc = 16'h0000, pc_e, mem_addr, pc_value;
  logic [7:0] reg_rdata, mem_wdata, mem_rdata, src_sel, psc_sel, wd_sel;
  logic mem_we, mem_re, core_stall, vec_valid, pc_load, key_open;
  logic [2:0] vec_num;
  logic [15:0] rd_q[$], pc_q[$], vec_q[$];
  logic [31:0] seed = 32'h2CEF;
  int miscompares = 0, n_compared = 0, cyc = 0;

  always #25 clk = ~clk;

  cisc_ctrl dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_done(instr_done), .op_push(ops[5]),
    .op_pop(ops[4]), .op_call(ops[3]), .op_ret(ops[2]), .op_interrupt_return(ops[1]),
    .op_sei(sei), .op_cli(ops[0]), .asleep(1'b0), .push_data(push_data),
    .ret_pc(ret_pc), .irq_evt(irq_evt), .irq_lvl(8'h00), .mem_we(mem_we),
    .mem_re(mem_re), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .core_stall(core_stall),
    .vec_valid(vec_valid), .vec_num(vec_num), .pc_load(pc_load),
    .pc_value(pc_value), .clock_source_select(src_sel),
    .clock_prescale_select(psc_sel), .watchdog_ctrl_status(wd_sel),
    .key_open(key_open));
  cisc_stack_mem u_mem (.clk(clk), .mem_we(mem_we), .mem_re(mem_re),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [15:0] take(ref logic [15:0] q[$]);
    return q.size() ? q.pop_front() : 16'hXXXX;
  endfunction : take
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back({8'h00, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  // sequences wait on the stall, bounded
  task automatic op(logic [5:0] o);
    int n;
    n = 0;
    @(posedge clk);
    ops <= o;
    instr_done <= 1'b1;
    ret_pc <= pc_e;
    push_data <= xs();
    @(posedge clk);
    ops <= 6'h00;
    instr_done <= 1'b0;
    #1;
    while (core_stall !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : op
  task automatic evt(logic [7:0] m);
    @(posedge clk);
    irq_evt <= m;
    @(posedge clk);
    irq_evt <= 8'h00;
  endtask : evt
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------------------------
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (resetn) begin
    if (rd_d) cmp("reg_rdata", take(rd_q), {8'h00, reg_rdata});
    if (pc_load) cmp("pc_value", take(pc_q), pc_value);
    if (vec_valid) cmp("vec_num", take(vec_q), {13'h0000, vec_num});
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      miscompares++;
      close_out();
    end
  end

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  initial begin
    pc_e = xs();
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd(6'h3F, 8'h00);
    rd(6'h3D, 8'h5F);
    rd(6'h3E, 8'h00);
    rd(6'h10, 8'h00);
    wr(6'h3D, 8'h5F);
    op(PUSH);
    rd(6'h3D, 8'h5E);
    op(POP);
    rd(6'h3D, 8'h5F);
    op(CALL);
    rd(6'h3D, 8'h5D);
    pc_q.push_back(pc_e);
    op(RET);
    rd(6'h3D, 8'h5F);
    wr(6'h39, 8'h5A);
    rd(6'h39, 8'h00);
    wr(6'h3C, 8'h55);
    rd(6'h3C, 8'h00);
    wr(6'h3C, 8'hD8);
    wr(6'h39, 8'h5A);
    rd(6'h3C, 8'h01);
    rd(6'h3C, 8'h00);
    rd(6'h39, 8'h5A);
    wr(6'h3B, 8'h07);
    evt(8'h0B);
    rd(6'h3A, 8'h0B);
    wr(6'h3A, 8'h08);
    rd(6'h3A, 8'h03);
    op(6'h00);
    wr(6'h3F, 8'h80);
    pc_e = xs();
    vec_q.push_back(16'h0000);
    op(6'h00);
    rd(6'h3F, 8'h00);
    rd(6'h3A, 8'h02);
    rd(6'h3D, 8'h5D);
    pc_q.push_back(pc_e);
    op(INTERRUPT_RETURN);
    rd(6'h3F, 8'h80);
    vec_q.push_back(16'h0001);
    op(6'h00);
    op(6'h00);
    pc_q.push_back(pc_e);
    op(INTERRUPT_RETURN);
    evt(8'h04);
    op(CLEAR_GLOBAL_IRQ);
    rd(6'h3F, 8'h00);
    wr(6'h3C, 8'hD8);
    wr(6'h3F, 8'h80);
    op(6'h00);
    vec_q.push_back(16'h0002);
    op(6'h00);
    pc_q.push_back(pc_e);
    op(INTERRUPT_RETURN);
    evt(8'h02);
    @(posedge clk);
    sei <= 1'b1;
    instr_done <= 1'b1;
    @(posedge clk);
    sei <= 1'b0;
    instr_done <= 1'b0;
    op(6'h00);
    vec_q.push_back(16'h0001);
    op(6'h00);
    pc_q.push_back(pc_e);
    op(INTERRUPT_RETURN);
    repeat (3) @(posedge clk);
    if (rd_q.size() + pc_q.size() + vec_q.size() != 0) begin
      miscompares++;
      $display("[ERR] pending notes expected 0 seen %0d",
               rd_q.size() + pc_q.size() + vec_q.size());
    end
    close_out();
  end
endmodule : test_cisc_ctrl
